// ### rtl/ref_fb_cfg_pkg.sv
package ref_fb_cfg_pkg;
	localparam logic [7:0] REF_PATH_OFFSET = 8'h1B;
	localparam logic [7:0] DEBUG_OFFSET = 8'h1C;
	localparam logic [7:0] FB_DIV_OFFSET = 8'h1D;
	localparam logic [15:0] REF_PATH_RESET = 16'h0000;
	localparam logic [15:0] DEBUG_RESET = 16'h0000;
	localparam logic [15:0] FB_DIV_RESET = 16'h000C;
	localparam int BYPASS_LSB = 11;
	localparam int COPY_EN_BIT = 10;
	localparam int COPY_SEL_BIT = 9;
	localparam int DIV_RST_BIT = 8;
	localparam int RDIV_LSB = 0;
	localparam int RDIV_W = 8;
	localparam int PRESCALE_LSB = 14;
	localparam int NDIV_W = 14;
	localparam logic [15:0] REF_PATH_MASK = 16'h7FFF;
	localparam logic [NDIV_W-1:0] NDIV_MIN = 14'h0006;
	localparam logic [2:0] PRESCALE_BASE = 3'h4;
	localparam logic [2:0] PRESCALE_MAX = 3'h6;
endpackage

// ### rtl/ref_divider_feedback_config.sv
`timescale 1ns/1ns
module ref_divider_feedback_config
	import ref_fb_cfg_pkg::*;
#(
	parameter int NUM_CHAN = 4
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic software_reset,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [15:0] reg_rdata,
	output logic reg_rdata_valid,
	input wire logic ref_clk_in,
	input wire logic [NUM_CHAN-1:0] chan_output_source_mux,
	output logic [NUM_CHAN-1:0] chan_bypass_route,
	output logic reference_copy_output,
	output logic phase_detector_clock,
	output logic reference_divider_reset,
	output logic [RDIV_W-1:0] reference_divider_ratio,
	output logic doubler_enable,
	output logic [2:0] feedback_prescale_ratio,
	output logic [NDIV_W-1:0] feedback_divider_ratio,
	output logic feedback_divider_below_min
);
	import ref_fb_cfg_pkg::*;

	initial begin
		if (NUM_CHAN != 4) $error("bypass enables exist for exactly four channels");
	end

	logic [15:0] ref_path_cfg, next_ref_path_cfg;
	logic [15:0] debug_cfg, next_debug_cfg;
	logic [15:0] fb_div_cfg, next_fb_div_cfg;
	logic [15:0] next_reg_rdata;
	logic next_reg_rdata_valid;
	logic in_reset, next_in_reset;

	// register writes; software reset returns every field to its default
	always_comb begin
		next_ref_path_cfg = ref_path_cfg;
		next_debug_cfg = debug_cfg;
		next_fb_div_cfg = fb_div_cfg;
		next_in_reset = 1'b0;
		if (software_reset) begin
			next_ref_path_cfg = REF_PATH_RESET;
			next_debug_cfg = DEBUG_RESET;
			next_fb_div_cfg = FB_DIV_RESET;
			next_in_reset = 1'b1;
		end else if (reg_write) begin
			unique case (reg_addr)
				REF_PATH_OFFSET: next_ref_path_cfg = reg_wdata & REF_PATH_MASK;
				DEBUG_OFFSET: next_debug_cfg = reg_wdata;
				FB_DIV_OFFSET: next_fb_div_cfg = reg_wdata;
				default: ;
			endcase
		end
	end

	// read port answers one cycle after the strobe; unmapped reads zero
	always_comb begin
		next_reg_rdata = reg_rdata;
		next_reg_rdata_valid = reg_read;
		if (reg_read) begin
			unique case (reg_addr)
				REF_PATH_OFFSET: next_reg_rdata = ref_path_cfg;
				DEBUG_OFFSET: next_reg_rdata = debug_cfg;
				FB_DIV_OFFSET: next_reg_rdata = fb_div_cfg;
				default: next_reg_rdata = 16'h0000;
			endcase
		end
	end

	// in_reset stays high for the first cycle after any reset ends
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ref_path_cfg <= REF_PATH_RESET;
			debug_cfg <= DEBUG_RESET;
			fb_div_cfg <= FB_DIV_RESET;
			reg_rdata <= 16'h0000;
			reg_rdata_valid <= 1'b0;
			in_reset <= 1'b1;
		end else begin
			ref_path_cfg <= next_ref_path_cfg;
			debug_cfg <= next_debug_cfg;
			fb_div_cfg <= next_fb_div_cfg;
			reg_rdata <= next_reg_rdata;
			reg_rdata_valid <= next_reg_rdata_valid;
			in_reset <= next_in_reset;
		end
	end

	// reference pin synchroniser: a change counts once stages two and three agree
	logic [2:0] ref_sync;
	logic ref_level, next_ref_level;
	always_comb begin
		next_ref_level = (ref_sync[1] == ref_sync[2]) ? ref_sync[2] : ref_level;
	end

	logic [RDIV_W-1:0] rdiv, div_count, next_div_count;
	logic div_hold, ref_rise, ref_edge, next_pfd;
	assign rdiv = ref_path_cfg[RDIV_LSB +: RDIV_W];
	// software reset itself counts, so the divider is held in the very cycle it is requested
	assign div_hold = ref_path_cfg[DIV_RST_BIT] | in_reset | software_reset;
	assign ref_edge = next_ref_level != ref_level;
	assign ref_rise = ref_edge & next_ref_level;

	// ratios 2 and up count reference rising edges, high for the first half of each period; ratio 0 toggles on each edge, ratio 1 follows the reference
	always_comb begin
		next_div_count = div_count;
		next_pfd = phase_detector_clock;
		if (div_hold) begin
			next_div_count = '0;
			next_pfd = 1'b0;
		end else if (rdiv == '0) begin
			if (ref_edge) next_pfd = ~phase_detector_clock;
		end else if (rdiv == 8'h01) begin
			next_pfd = next_ref_level;
		end else if (ref_rise) begin
			next_div_count = (div_count >= rdiv - 8'h01) ? '0 : div_count + 8'h01;
			// nine bits so that ratio 255 does not wrap the half-period bound to zero
			next_pfd = {1'b0, next_div_count} < (({1'b0, rdiv} + 9'h001) >> 1);
		end
	end

	// copy output is forced low when disabled rather than left floating
	logic next_copy;
	always_comb begin
		next_copy = 1'b0;
		if (ref_path_cfg[COPY_EN_BIT]) begin
			next_copy = ref_path_cfg[COPY_SEL_BIT] ? next_pfd : next_ref_level;
		end
	end

	// prescaler code 3 is undefined; it falls back to the largest ratio
	logic [1:0] ps_code;
	logic [2:0] next_prescale;
	logic [NDIV_W-1:0] ndiv, next_ndiv;
	assign ps_code = fb_div_cfg[PRESCALE_LSB +: 2];
	assign ndiv = fb_div_cfg[NDIV_W-1:0];
	always_comb begin
		next_prescale = (ps_code == 2'h3) ? PRESCALE_MAX : PRESCALE_BASE + {1'b0, ps_code};
		next_ndiv = (ndiv < NDIV_MIN) ? NDIV_MIN : ndiv;
	end

	logic [NUM_CHAN-1:0] next_route;
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
			// bypass source only reaches the mux through its enabled buffer
			assign next_route[ch] = ref_path_cfg[BYPASS_LSB + ch] & chan_output_source_mux[ch];
		end
	endgenerate

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ref_sync <= 3'h0;
			ref_level <= 1'b0;
			div_count <= '0;
			phase_detector_clock <= 1'b0;
			reference_copy_output <= 1'b0;
			chan_bypass_route <= '0;
			reference_divider_reset <= 1'b1;
			reference_divider_ratio <= REF_PATH_RESET[RDIV_W-1:0];
			doubler_enable <= 1'b0;
			feedback_prescale_ratio <= PRESCALE_BASE;
			feedback_divider_ratio <= FB_DIV_RESET[NDIV_W-1:0];
			feedback_divider_below_min <= 1'b0;
		end else begin
			ref_sync <= {ref_sync[1:0], ref_clk_in};
			ref_level <= next_ref_level;
			div_count <= next_div_count;
			phase_detector_clock <= next_pfd;
			reference_copy_output <= next_copy;
			chan_bypass_route <= next_route;
			reference_divider_reset <= div_hold;
			reference_divider_ratio <= rdiv;
			doubler_enable <= rdiv == '0;
			feedback_prescale_ratio <= next_prescale;
			feedback_divider_ratio <= next_ndiv;
			feedback_divider_below_min <= ndiv < NDIV_MIN;
		end
	end
endmodule

// ### sim/ref_fb_checker.sv
`timescale 1ns/1ns
module ref_fb_checker (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic software_reset,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic reg_rdata_valid,
	input wire logic [3:0] chan_bypass_route,
	input wire logic reference_copy_output,
	input wire logic reference_divider_reset,
	input wire logic [7:0] reference_divider_ratio,
	input wire logic doubler_enable,
	input wire logic [2:0] feedback_prescale_ratio,
	input wire logic feedback_divider_below_min
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// accepted writes; software reset wins over them
	wire w1 = reg_write && reg_addr == 8'h1B && !software_reset;
	wire w3 = reg_write && reg_addr == 8'h1D && !software_reset;
	read_valid_a: assert property (reg_read |=> reg_rdata_valid) else $error("read valid");
	ref_ratio_a: assert property (w1 |=> ##1 reference_divider_ratio == 8'($past(reg_wdata, 2))) else $error("ratio");
	doubler_on_a: assert property (w1 |=> ##1 doubler_enable == (8'($past(reg_wdata, 2)) == 8'h00)) else $error("dbl");
	bypass_gate_a: assert property (w1 |=> ##1 (chan_bypass_route & ~4'($past(reg_wdata, 2) >> 11)) == 4'h0) else $error("route");
	copy_off_a: assert property (w1 && !reg_wdata[10] |=> ##1 !reference_copy_output) else $error("copy");
	div_reset_a: assert property (software_reset |=> reference_divider_reset) else $error("rdrst");
	prescale_a: assert property (w3 |=> ##1 feedback_prescale_ratio == ($past(reg_wdata[15], 2) ? 3'h6 : 3'h4 + 3'($past(reg_wdata[14], 2)))) else $error("pre");
	ndiv_low_a: assert property (w3 |=> ##1 feedback_divider_below_min == (14'($past(reg_wdata, 2)) < 14'h0006)) else $error("low");
endmodule
bind ref_divider_feedback_config ref_fb_checker i_chk (.*);

// ### sim/testbench.sv
`timescale 1ns/1ns
module testbench;
	logic mclk = 1'b0, rst_b = 1'b0, software_reset = 1'b0, reg_write = 1'b0, reg_read = 1'b0, ref_clk_in = 1'b0;
	logic [7:0] reg_addr = 8'h00, reference_divider_ratio;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata;
	logic [3:0] chan_output_source_mux = 4'hF, chan_bypass_route;
	logic reg_rdata_valid, reference_copy_output, phase_detector_clock, reference_divider_reset;
	logic doubler_enable, feedback_divider_below_min;
	logic [2:0] feedback_prescale_ratio;
	logic [13:0] feedback_divider_ratio;
	int err_count = 0, n_checks = 0, cyc = 0;
	always #20 mclk = ~mclk;
	ref_divider_feedback_config i_dut (.*);
	task automatic chk(input string s, input logic [15:0] e, g);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s exp %h got %h", s, e, g);
		end
	endtask
	// waits two more cycles so derived outputs have settled
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1'b1;
		@(negedge mclk);
		reg_write = 1'b0;
		repeat (2) @(negedge mclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(negedge mclk);
		reg_addr = a;
		reg_read = 1'b1;
		@(negedge mclk);
		reg_read = 1'b0;
		chk("rdata", e, reg_rdata);
	endtask
	task automatic t_ref;
		wr(8'h1B, 16'h7FFF);
		rd(8'h1B, 16'h7FFF);
		chk("ratio", 16'h00FF, reference_divider_ratio);
		chk("rdrst", 16'h0001, reference_divider_reset);
		chk("route", 16'h000F, chan_bypass_route);
		wr(8'h1B, 16'h0400);
		ref_clk_in = 1'b1;
		repeat (6) @(negedge mclk);
		chk("copy", 16'h0001, reference_copy_output);
		chk("route", 16'h0000, chan_bypass_route);
		chk("dbl", 16'h0001, doubler_enable);
		wr(8'h1B, 16'h0001);
		chk("pfd", 16'h0001, phase_detector_clock);
		wr(8'h1B, 16'h0000);
		chk("copy", 16'h0000, reference_copy_output);
	endtask
	// codes 0..2 with divider 6, 7, 8; software never goes below the minimum
	task automatic t_fb;
		for (int i = 0; i < 3; i++) begin
			wr(8'h1D, {2'(i), 14'(6 + i)});
			chk("pre", 16'(4 + i), feedback_prescale_ratio);
			chk("ndiv", 16'(6 + i), feedback_divider_ratio);
			chk("low", 16'h0000, feedback_divider_below_min);
		end
	endtask
	task automatic t_misc;
		wr(8'h1C, 16'h0000);
		rd(8'h1C, 16'h0000);
		rd(8'h20, 16'h0000);
		@(negedge mclk);
		software_reset = 1'b1;
		@(negedge mclk);
		software_reset = 1'b0;
		chk("rdrst", 16'h0001, reference_divider_reset);
		rd(8'h1D, 16'h000C);
	endtask
	task final_report;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// hang guard, far above the under sixty cycles needed
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			final_report;
		end
	end
	initial begin
		repeat (8) @(negedge mclk);
		rst_b = 1'b1;
		rd(8'h1D, 16'h000C);
		t_ref;
		t_fb;
		t_misc;
		final_report;
	end
endmodule
